// ==== dv/framer_sva.sv ====
// Purpose: port checks for the framer
// Assumes: config ports held during a package
// Notes:   bound to every framer instance
`timescale 1ns/1ps
`default_nettype none
module framer_sva
  import app_payload_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [1:0]  format,
  input wire logic [7:0]  tag_byte,
  input wire logic [31:0] dest_node_address,
  input wire logic [7:0]  adc_resolution,
  input wire logic [47:0] adc_result,
  input wire logic [13:0] temp_reading,
  input wire logic [11:0] hum_reading,
  input wire logic [4:0]  nbr_count,
  input wire logic [31:0] pkt_dest_node_address,
  input wire logic [7:0]  pkt_data,
  input wire logic        pkt_valid,
  input wire logic        pkt_last,
  input wire logic        pkt_ready,
  input wire logic        busy
);
  logic [4:0] cnt_r;
  logic [4:0] len_t;
  wire        hs = pkt_valid && pkt_ready;
  wire        gp = format == FMT_GPIO;
  assign len_t = gp ? 5'h0d : (format == FMT_SENSOR) ? 5'h05 :
                 (nbr_count > 5'h05) ? 5'h10 : 5'h01 + 5'h03 * nbr_count;
  // byte position inside the current package
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (hs && pkt_last))
      cnt_r <= 5'h00;
    else if (hs)
      cnt_r <= cnt_r + 5'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_hs; pkt_valid && pkt_ready; endsequence
  sequence s_wait; pkt_valid && !pkt_ready; endsequence
  AST_RST:
    assert property (disable iff (1'b0) !rst_n |=> !pkt_valid && !busy)
    else $error("output active after reset");
  AST_HOLD:
    assert property (s_wait |=> pkt_valid && $stable(pkt_data)
      && $stable(pkt_last)) else $error("byte dropped while stalled");
  AST_BUSY:
    assert property (pkt_valid |-> busy) else $error("busy low in send");
  AST_ANS:
    assert property ($rose(busy) |=> pkt_valid) else $error("late start");
  AST_TAG:
    assert property (pkt_valid && cnt_r == 5'h00 |-> pkt_data == tag_byte)
    else $error("first byte not tag");
  AST_DEST:
    assert property (pkt_valid |-> pkt_dest_node_address
      == dest_node_address) else $error("wrong destination");
  AST_LEN:
    assert property (s_hs |-> pkt_last == (cnt_r == len_t - 5'h01))
    else $error("package length wrong");
  AST_TEMP:
    assert property (pkt_valid && format == FMT_SENSOR && cnt_r == 5'h02
      |-> pkt_data == {temp_reading[5:0], 2'h0}) else $error("temp low");
  AST_HUM:
    assert property (pkt_valid && format == FMT_SENSOR && cnt_r == 5'h04
      |-> pkt_data == {hum_reading[3:0], 4'h0}) else $error("hum low");
  AST_ADC:
    assert property (pkt_valid && gp && adc_resolution == RES_12 &&
      cnt_r == 5'h06 |-> pkt_data == {adc_result[3:0], 4'h0})
    else $error("adc low byte");
endmodule
bind app_payload_framer framer_sva u_sva (.clk_sys, .rst_n, .format,
  .tag_byte, .dest_node_address, .adc_resolution, .adc_result,
  .temp_reading, .hum_reading, .nbr_count, .pkt_dest_node_address,
  .pkt_data, .pkt_valid, .pkt_last, .pkt_ready, .busy);
`default_nettype wire

// ==== dv/mesh_sink.sv ====
// Purpose: mesh transmit path taking package bytes
// Assumes: stall makes ready drop every other pair of cycles
// Notes:   keeps the last package and its start cycle
`timescale 1ns/1ps
`default_nettype none
module mesh_sink (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] pkt_data,
  input wire logic       pkt_valid,
  input wire logic       pkt_last,
  input wire logic       stall,
  output logic           pkt_ready
);
  logic [7:0] rx [0:15];
  logic       in_pkt;
  int         n, len, pkts, t_start, cyc;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      {pkt_ready, in_pkt} <= 2'h0;
      {n, len, pkts, cyc} <= '0;
    end else begin
      pkt_ready <= !stall || cyc[1];
      if (pkt_valid && !in_pkt) begin
        t_start <= cyc;
        in_pkt <= 1'b1;
      end
      if (pkt_valid && pkt_ready) begin
        rx[n[3:0]] <= pkt_data;
        n <= n + 1;
        if (pkt_last) begin
          {n, in_pkt} <= '0;
          len <= n + 1;
          pkts <= pkts + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: package content and timing tests
// Assumes: TICK of 10 cycles per second
// Notes:   seven packages in three formats
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import app_payload_pkg::*;
  localparam int TK = 10;
  logic        clk_sys, rst_n, enable, counter_enable, nbr_we, stall;
  logic        pkt_valid, pkt_last, pkt_ready, busy;
  logic [1:0]  format, interval_unit;
  logic [7:0]  tag_byte, interval_value, pin_in, adc_resolution, nbr_wdbm;
  logic [7:0]  pkt_data;
  logic [7:0]  e [0:15];
  logic [31:0] dest_node_address, pkt_dest_node_address;
  logic [2:0]  counter_pin;
  logic [47:0] adc_result;
  logic [13:0] temp_reading;
  logic [11:0] hum_reading;
  logic [3:0]  nbr_waddr;
  logic [15:0] nbr_wnode_address, w;
  logic [4:0]  nbr_count;
  int          err_count, cmp_count, cyc, t0, k, x;
  app_payload_framer #(.TICK(TK), .NBR_N(16)) u_dut (.clk_sys, .rst_n,
    .enable, .format, .tag_byte, .dest_node_address, .interval_value,
    .interval_unit, .pin_in, .counter_enable, .counter_pin,
    .adc_resolution, .adc_result, .temp_reading, .hum_reading, .nbr_we,
    .nbr_waddr, .nbr_wnode_address, .nbr_wdbm, .nbr_count,
    .pkt_dest_node_address, .pkt_data, .pkt_valid, .pkt_last,
    .pkt_ready, .busy);
  mesh_sink u_sink (.clk_sys, .rst_n, .pkt_data, .pkt_valid, .pkt_last,
    .stall, .pkt_ready);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_pkt(input int p);
    k = 0;
    while (u_sink.pkts < p && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    chk(u_sink.pkts, p);
    @(negedge clk_sys);
  endtask
  task automatic chk_pkt(input int len);
    chk(u_sink.len, len);
    for (int i = 0; i < len; i++)
      chk(u_sink.rx[i], e[i]);
  endtask
  task automatic fill_gpio(input logic [7:0] fl, input logic [15:0] ct);
    e[0] = tag_byte;
    e[1] = fl;
    e[2] = pin_in;
    e[3] = ct[15:8];
    e[4] = ct[7:0];
    for (int c = 0; c < 4; c++) begin
      w = (adc_resolution == RES_12) ? {adc_result[c*12+:12], 4'h0}
                                     : {adc_result[c*12+:7], 9'h000};
      e[5+2*c] = w[15:8];
      e[6+2*c] = w[7:0];
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, enable, counter_enable, nbr_we, stall} = '0;
    {err_count, cmp_count, cyc} = '0;
    {temp_reading, hum_reading, nbr_waddr, nbr_count} = '0;
    {nbr_wnode_address, nbr_wdbm} = '0;
    format = FMT_GPIO;
    tag_byte = 8'h5a;
    dest_node_address = 32'h1234abcd;
    interval_value = 8'h01;
    interval_unit = UNIT_SEC;
    pin_in = 8'ha4;
    counter_pin = 3'h2;
    adc_resolution = RES_12;
    adc_result = 48'h9ab_456_801_7ff;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    counter_enable = 1;
    enable = 1;
    wait_pkt(1);
    t0 = u_sink.t_start;
    stall = 1;
    repeat (3) begin
      pin_in[2] = 0;
      repeat (4) @(negedge clk_sys);
      pin_in[2] = 1;
      repeat (4) @(negedge clk_sys);
    end
    pin_in[0] = 1;
    pin_in[7] = 0;
    fill_gpio(8'h84, 16'h0003);
    wait_pkt(2);
    chk(u_sink.t_start - t0, SEC_MIN * TK);
    chk_pkt(13);
    adc_resolution = RES_7;
    fill_gpio(8'h00, 16'h0000);
    wait_pkt(3);
    chk_pkt(13);
    format = FMT_SENSOR;
    temp_reading = 14'h2abc;
    hum_reading = 12'hdef;
    dest_node_address = 32'h0badf00d;
    e[1] = temp_reading[13:6];
    e[2] = {temp_reading[5:0], 2'h0};
    e[3] = hum_reading[11:4];
    e[4] = {hum_reading[3:0], 4'h0};
    for (int i = 0; i < 7; i++) begin
      nbr_we = 1;
      nbr_waddr = 4'(i);
      nbr_wnode_address = 16'h1000 + 16'(i) * 16'h0111;
      nbr_wdbm = 8'h28 + 8'(i);
      @(negedge clk_sys);
    end
    nbr_we = 0;
    wait_pkt(4);
    chk_pkt(5);
    chk(pkt_dest_node_address, dest_node_address);
    format = FMT_NEIGHBOUR;
    nbr_count = 5'h07;
    for (int p = 0; p < 3; p++) begin
      if (p == 2)
        nbr_count = 5'h03;
      for (int j = 0; j < 5; j++) begin
        x = (p == 2) ? j : (p * 5 + j) % 7;
        w = 16'h1000 + 16'(x) * 16'h0111;
        e[1+3*j] = w[15:8];
        e[2+3*j] = w[7:0];
        e[3+3*j] = 8'h28 + 8'(x);
      end
      wait_pkt(5 + p);
      chk_pkt((p == 2) ? 10 : 16);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== rtl/app_payload_framer.sv ====
// Purpose: builds self-generated payload packages for the mesh stack
// Assumes: pins asynchronous; sensor and neighbour data on clk_sys
// Notes:   one package per interval, bytes streamed with last marker
// Notes on behaviour
// - tag byte is first byte of every package.
// - each package carries the configured four-byte destination address.
// - packages sent periodically, interval 10 s to 24 h, unit selectable.
// - gpio package: tag, edge flags, pin states, counter, four adc words.
// - flag bit 7 is pin_seven, bit 0 is pin_zero.
// - flag bit set only by a falling edge during the period.
// - pin-state byte is pin levels at generation, same bit order.
// - counter holds falling edges on the counter pin this interval.
// - adc fields are two's complement of width 7, 9, 10 or 12.
// - adc result left aligned, low unused bits zero.
// - sensor package: tag then 14-bit msb-aligned temperature.
// - then 12-bit msb-aligned humidity.
// - neighbour package: up to five entries, address then signal byte.
// - more than five neighbours rotate in groups of five with wrap.
// - signal byte is positive magnitude in negative dBm.
// - one counter pin at most, count since previous package.
`timescale 1ns/1ps
`default_nettype none
module app_payload_framer
  import app_payload_pkg::*;
#(
  parameter int TICK = app_payload_pkg::TICK_CYCLES,
  parameter int NBR_N = app_payload_pkg::NBR_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 enable,
  input  wire logic [1:0]           format,
  input  wire logic [7:0]           tag_byte,
  input  wire logic [31:0]          dest_node_address,
  input  wire logic [7:0]           interval_value,
  input  wire logic [1:0]           interval_unit,
  input  wire logic [7:0]           pin_in,
  input  wire logic                 counter_enable,
  input  wire logic [2:0]           counter_pin,
  input  wire logic [7:0]           adc_resolution,
  input  wire logic [4*12-1:0]      adc_result,
  input  wire logic [13:0]          temp_reading,
  input  wire logic [11:0]          hum_reading,
  input  wire logic                 nbr_we,
  input  wire logic [3:0]           nbr_waddr,
  input  wire logic [15:0]          nbr_wnode_address,
  input  wire logic [7:0]           nbr_wdbm,
  input  wire logic [4:0]           nbr_count,
  output logic [31:0]               pkt_dest_node_address,
  output logic [7:0]                pkt_data,
  output logic                      pkt_valid,
  output logic                      pkt_last,
  input  wire logic                 pkt_ready,
  output logic                      busy
);
  import app_payload_pkg::*;

  typedef enum {ST_IDLE, ST_SEND} state_e;
  state_e state_r;

  // pin synchroniser and falling-edge capture
  logic [7:0]  pin_s1_r;
  logic [7:0]  pin_s2_r;
  logic [7:0]  pin_d_r;
  logic [7:0]  edge_flags_r;
  logic [15:0] edge_cnt_r;
  wire  [7:0]  fall = pin_d_r & ~pin_s2_r;
  wire         cnt_fall = counter_enable && fall[counter_pin];

  // interval timer: second tick then second count
  logic [31:0] tick_r;
  logic [16:0] sec_r;
  wire         sec_tick = tick_r == 32'(TICK - 1);
  // product kept at full width so that long hour settings clamp, not wrap
  wire  [31:0] raw_sec = interval_unit == UNIT_HOUR ?
                 32'(interval_value) * 32'(SEC_PER_HOUR) :
                 interval_unit == UNIT_MIN ?
                 32'(interval_value) * 32'(SEC_PER_MIN) :
                 32'(interval_value);
  // clamp to the permitted interval range
  wire  [16:0] sec_lim = raw_sec < 32'(SEC_MIN) ? 17'(SEC_MIN) :
                 raw_sec > 32'(SEC_MAX) ? 17'(SEC_MAX) :
                 raw_sec[16:0];
  wire         fire = enable && sec_tick && (sec_r >= sec_lim - 17'h1)
                 && state_r == ST_IDLE;

  // neighbour table and rotation
  logic [15:0] nbr_addr_mem [NBR_N];
  logic [7:0]  nbr_dbm_mem [NBR_N];
  logic [4:0]  rot_r;
  logic [2:0]  nsend_r;

  // snapshot image of the package
  logic [7:0]  img_r [MAX_LEN];
  logic [4:0]  len_r;
  logic [4:0]  idx_r;
  logic [7:0]  img_nxt [MAX_LEN];
  logic [4:0]  len_nxt;
  logic [2:0]  nsend_nxt;

  // left-align an adc result of the selected width
  function automatic logic [15:0] adc_align(input logic [11:0] v,
                                            input logic [7:0] res);
    logic [15:0] r;
    r = 16'h0000;
    case (res)
      RES_7:   r = {v[6:0], 9'h000};
      RES_9:   r = {v[8:0], 7'h00};
      RES_10:  r = {v[9:0], 6'h00};
      default: r = {v[11:0], 4'h0};
    endcase
    return r;
  endfunction

  // aligned adc words, one per channel
  logic [15:0] adc_w [ADC_CH];
  for (genvar c = 0; c < ADC_CH; c++) begin : g_adc
    assign adc_w[c] = adc_align(adc_result[c*12 +: 12], adc_resolution);
  end

  logic [4:0] ni;
  logic [4:0] base;
  always_comb begin
    for (int i = 0; i < MAX_LEN; i++) img_nxt[i] = 8'h00;
    len_nxt   = 5'h0;
    nsend_nxt = 3'h0;
    ni        = 5'h0;
    base      = 5'h0;
    img_nxt[0] = tag_byte;
    case (fmt_e'(format))
      FMT_GPIO: begin
        img_nxt[1] = edge_flags_r | fall;
        img_nxt[2] = pin_s2_r;
        img_nxt[3] = edge_cnt_r[15:8];
        img_nxt[4] = edge_cnt_r[7:0];
        for (int c = 0; c < ADC_CH; c++) begin
          img_nxt[5+2*c] = adc_w[c][15:8];
          img_nxt[6+2*c] = adc_w[c][7:0];
        end
        len_nxt = 5'(GPIO_LEN);
      end
      FMT_SENSOR: begin
        img_nxt[1] = temp_reading[13:6];
        img_nxt[2] = {temp_reading[5:0], 2'h0};
        img_nxt[3] = hum_reading[11:4];
        img_nxt[4] = {hum_reading[3:0], 4'h0};
        len_nxt = 5'(SENS_LEN);
      end
      FMT_NEIGHBOUR: begin
        base = rot_r < nbr_count ? rot_r : 5'h0;
        for (int e = 0; e < NBR_PER_PKT; e++) begin
          if (5'(e) < nbr_count) begin
            ni = 5'(base + 5'(e));
            if (ni >= nbr_count) ni = 5'(ni - nbr_count);
            img_nxt[1+3*e] = nbr_addr_mem[ni[3:0]][15:8];
            img_nxt[2+3*e] = nbr_addr_mem[ni[3:0]][7:0];
            img_nxt[3+3*e] = nbr_dbm_mem[ni[3:0]];
            nsend_nxt = 3'(e + 1);
          end
        end
        len_nxt = 5'(1 + NBR_ENTRY_LEN * nsend_nxt);
      end
      default: len_nxt = 5'h1;
    endcase
  end

  // stream through the two-entry buffer
  logic       buf_in_ready;
  wire        in_valid = state_r == ST_SEND;
  wire        last_b   = idx_r == len_r - 5'h1;
  wire        push     = in_valid && buf_in_ready;
  logic [8:0] buf_out;

  byte_skid_buffer #(.W(9)) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   ({last_b, img_r[idx_r[3:0]]}),
    .in_valid  (in_valid),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out),
    .out_valid (pkt_valid),
    .out_ready (pkt_ready)
  );
  assign pkt_data = buf_out[7:0];
  assign pkt_last = buf_out[8];
  assign busy     = state_r == ST_SEND || pkt_valid;

  always_ff @(posedge clk_sys) begin
    if (nbr_we) begin
      nbr_addr_mem[nbr_waddr] <= nbr_wnode_address;
      nbr_dbm_mem[nbr_waddr]  <= nbr_wdbm;
    end
    if (fire) begin
      for (int i = 0; i < MAX_LEN; i++) img_r[i] <= img_nxt[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_d_r  <= 8'h00;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      edge_flags_r <= 8'h00;
      edge_cnt_r   <= 16'h0000;
    end else if (fire) begin
      edge_flags_r <= 8'h00;
      edge_cnt_r   <= {15'h0000, cnt_fall};
    end else begin
      edge_flags_r <= edge_flags_r | fall;
      if (cnt_fall && edge_cnt_r != 16'hffff) begin
        edge_cnt_r <= edge_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable) begin
      tick_r <= 32'h0;
      sec_r  <= 17'h0;
    end else if (sec_tick) begin
      tick_r <= 32'h0;
      sec_r  <= fire || sec_r >= sec_lim - 17'h1 ? 17'h0 : sec_r + 17'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  // sequencing decode
  wire         send_done = state_r == ST_SEND && push && last_b;
  wire         nbr_pkt   = format == 2'(FMT_NEIGHBOUR);
  wire         nbr_wrap  = nbr_count > 5'(NBR_PER_PKT);
  wire  [4:0]  rot_step  = 5'(rot_r + 5'(NBR_PER_PKT));
  wire  [4:0]  rot_next  = nbr_wrap ? 5'(rot_step % nbr_count) : 5'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (fire) begin
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (send_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // byte index inside the package image
  always_ff @(posedge clk_sys) begin
    if (!rst_n || fire) begin
      idx_r <= 5'h0;
    end else if (state_r == ST_SEND && push) begin
      idx_r <= idx_r + 5'h1;
    end
  end

  // package length and entry count latched with the snapshot
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      len_r   <= 5'h1;
      nsend_r <= 3'h0;
    end else if (fire) begin
      len_r   <= len_nxt;
      nsend_r <= nsend_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pkt_dest_node_address <= 32'h0;
    end else if (fire) begin
      pkt_dest_node_address <= dest_node_address;
    end
  end

  // next group of neighbours once a neighbour package is out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rot_r <= 5'h0;
    end else if (send_done && nbr_pkt) begin
      rot_r <= rot_next;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/app_payload_pkg.sv ====
// Purpose: shared constants for the payload framer
// Assumes: 100 MHz clk_sys
// Notes:   formats, field widths and timing figures
package app_payload_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int SEC_MIN         = 10;
  localparam int SEC_MAX         = 86400;
  localparam int TICK_CYCLES     = CLK_HZ;
  localparam int PINS            = 8;
  localparam int ADC_CH          = 4;
  localparam int NBR_PER_PKT     = 5;
  localparam int NBR_DEPTH       = 16;
  localparam logic [7:0] RES_7   = 8'h07;
  localparam logic [7:0] RES_9   = 8'h09;
  localparam logic [7:0] RES_10  = 8'h0a;
  localparam logic [7:0] RES_12  = 8'h0c;
  localparam int TEMP_BITS       = 14;
  localparam int HUM_BITS        = 12;
  localparam int GPIO_LEN        = 13;
  localparam int SENS_LEN        = 5;
  localparam int NBR_ENTRY_LEN   = 3;
  localparam int MAX_LEN         = 16;
  localparam logic [1:0] UNIT_SEC  = 2'h0;
  localparam logic [1:0] UNIT_MIN  = 2'h1;
  localparam logic [1:0] UNIT_HOUR = 2'h2;
  localparam int SEC_PER_MIN     = 60;
  localparam int SEC_PER_HOUR    = 3600;
  typedef enum logic [1:0] {FMT_GPIO, FMT_SENSOR, FMT_NEIGHBOUR} fmt_e;
endpackage

// ==== rtl/byte_skid_buffer.sv ====
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   carries a byte plus a last marker
`timescale 1ns/1ps
`default_nettype none
module byte_skid_buffer #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;
  assign in_ready  = cnt_r != 2'h2;
  assign out_valid = cnt_r != 2'h0;
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge clk_sys) begin
    if (push) mem_r[wp_r] <= in_data;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire
